// [hw/occu_command_unit.sv]
`timescale 1ns/100ps
module occu_command_unit
	import occu_pkg::*;
(
	// clock, reset, enable
	input  wire logic               clk,
	input  wire logic               sys_rst,
	input  wire logic               clk_en,
	// command from channel
	input  wire logic               cmd_valid,
	input  wire logic [7:0]         cmd_code,
	input  wire logic [OCCU_AW-1:0] cmd_addr,
	input  wire occu_kind_t         cmd_kind,
	input  wire logic               dev_configured,
	input  wire logic [1:0]         unit_state,
	output      logic               cmd_ready_q,
	// status byte to channel
	output      logic               stat_valid_q,
	output      logic [7:0]         stat_byte_q,
	input  wire logic               stat_accept,
	// orders to outboard devices
	output      logic               ord_valid_q,
	output      occu_ord_t          ord_code_q,
	output      logic [OCCU_AW-1:0] ord_addr_q,
	// communication bit updates
	output      logic               comm_upd_valid_q,
	output      logic [OCCU_AW-1:0] comm_upd_addr_q,
	output      logic               comm_upd_on_q,
	// error report from device
	input  wire logic               dev_rpt_valid,
	input  wire logic [OCCU_AW-1:0] dev_rpt_addr,
	input  wire occu_kind_t         dev_rpt_kind,
	input  wire logic [7:0]         dev_rpt_raw0,
	input  wire logic [7:0]         dev_rpt_raw1,
	input  wire logic               dev_power_lost,
	input  wire logic [31:0]        console_map,
	output      logic               rpt_ready_q,
	output      logic               rpt_ack_q,
	// formatted report bytes
	output      logic [7:0]         rpt_byte0_q,
	output      logic [7:0]         rpt_byte1_q,
	output      logic [7:0]         rpt_byte2_q,
	output      logic [7:0]         rpt_byte3_q
);

	// sequencer states
	typedef enum logic [2:0] {
		ST_CLEAR,
		ST_IDLE,
		ST_EXEC,
		ST_STATUS,
		ST_ATTN,
		ST_REPORT
	} occu_state_t;

	occu_state_t        state_q, state_d;   // sequencer
	logic [OCCU_AW-1:0] clr_cnt_q;          // reset sweep address
	logic [OCCU_AW-1:0] addr_q;             // address in work
	logic [7:0]         code_q;             // latched command byte
	occu_kind_t         kind_q;             // latched device kind
	logic               cfg_q;              // latched configured level
	logic [1:0]         ustate_q;           // latched unit state
	logic               power_lost_q;       // latched power loss
	logic               attn_after_q;       // attention follows status
	logic [OCCU_FW-1:0] flags_q;            // flags of address in work

	// memory ports
	logic [OCCU_FW-1:0] mem_rd;             // flags read back
	logic [OCCU_AW-1:0] mem_rd_addr;        // read address
	logic               mem_we;             // write enable
	logic [OCCU_AW-1:0] mem_wr_addr;        // write address
	logic [OCCU_FW-1:0] mem_wr_data;        // write data

	// handshakes
	logic cmd_take;     // command taken this cycle
	logic rpt_take;     // report taken this cycle
	logic sweep_done;   // last flag word cleared

	// command decode
	occu_cmd_t cmd;          // decoded command
	logic      is_order;     // resume, disable-interfaces or test
	logic      is_comm;      // either communication command
	logic      kind_bad;     // data adapter or unknown code
	logic      state_bad;    // communication refused by state
	logic      cmd_ok;       // command will be carried out
	logic      comm_live;    // communication bit really changes
	logic [7:0] exec_stat;   // initial selection status
	logic [OCCU_FW-1:0] exec_flags; // flags after the command
	logic      exec_attn;    // attention to follow the status

	// report path
	logic               fmt_err;       // error-capable bits seen
	logic               rpt_error;     // device error report
	logic [OCCU_FW-1:0] rpt_flags;     // flags after the report
	logic               rpt_attn;      // report gives attention now
	logic               attn_done;     // attention byte accepted

	// handshakes qualify on the registered ready flags
	assign cmd_take   = cmd_valid & cmd_ready_q;
	assign rpt_take   = dev_rpt_valid & rpt_ready_q & ~cmd_valid;
	assign sweep_done = (clr_cnt_q == OCCU_ADDR_LAST);
	assign attn_done  = (state_q == ST_ATTN) & stat_accept;

	// command decode from latched byte
	assign cmd      = occu_decode(code_q);
	assign is_order = (cmd == OCCU_CMD_RESUME) |
		(cmd == OCCU_CMD_DISABLE_INTF) | (cmd == OCCU_CMD_TEST);
	assign is_comm  = (cmd == OCCU_CMD_COMM_ON) |
		(cmd == OCCU_CMD_COMM_OFF);
	assign kind_bad = (cmd == OCCU_CMD_NONE) |
		(kind_q == OCCU_KIND_DATA_ADAPTER);
	// communication refused outside states three and zero
	assign state_bad = is_comm & (ustate_q != OCCU_STATE_THREE) &
		(ustate_q != OCCU_STATE_ZERO);
	assign cmd_ok    = ~kind_bad & ~state_bad & cfg_q;
	// state zero use is maintenance only, configuration untouched
	assign comm_live = cmd_ok & is_comm &
		(ustate_q == OCCU_STATE_THREE);

	// initial selection status, priority reject, state, configuration
	assign exec_stat = kind_bad ? OCCU_ST_UNIT_CHECK :
		(state_bad ? OCCU_ST_UNIT_EXC :
		(~cfg_q ? OCCU_ST_UNIT_EXC :
		(OCCU_ST_CHAN_END | OCCU_ST_DEV_END)));

	// flag word after an accepted command
	always_comb begin
		exec_flags = mem_rd;
		if (cmd_ok) begin
			unique case (cmd)
				OCCU_CMD_ATTN_ON:  exec_flags[OCCU_F_ATTN_EN] = 1'b1;
				OCCU_CMD_ATTN_OFF: exec_flags[OCCU_F_ATTN_EN] = 1'b0;
				OCCU_CMD_TEST:     exec_flags[OCCU_F_TEST] = 1'b1;
				OCCU_CMD_COMM_ON:  exec_flags[OCCU_F_COMM] = comm_live |
					mem_rd[OCCU_F_COMM];
				OCCU_CMD_COMM_OFF: exec_flags[OCCU_F_COMM] = ~comm_live &
					mem_rd[OCCU_F_COMM];
				default:           exec_flags = mem_rd;
			endcase
		end
	end

	// attention after the ending status, never merged into it
	assign exec_attn = cmd_ok & (
		((cmd == OCCU_CMD_TEST) & (ustate_q == OCCU_STATE_ZERO)) |
		((cmd == OCCU_CMD_ATTN_ON) & mem_rd[OCCU_F_PENDING]));

	// error report: error-out bits or power drop marks it pending
	assign rpt_error = fmt_err | power_lost_q;
	always_comb begin
		rpt_flags = mem_rd;
		rpt_flags[OCCU_F_TEST] = 1'b0;
		rpt_flags[OCCU_F_PENDING] = mem_rd[OCCU_F_PENDING] | rpt_error;
	end
	assign rpt_attn = rpt_error & mem_rd[OCCU_F_ATTN_EN];

	// flag memory address and write selection
	assign mem_rd_addr = (state_q != ST_IDLE) ? addr_q :
		(cmd_valid ? cmd_addr : dev_rpt_addr);
	assign mem_we = (state_q == ST_CLEAR) | (state_q == ST_EXEC) |
		(state_q == ST_REPORT) | attn_done;
	assign mem_wr_addr = (state_q == ST_CLEAR) ? clr_cnt_q : addr_q;
	always_comb begin
		unique case (state_q)
			ST_CLEAR:  mem_wr_data = OCCU_FLAGS_RST;
			ST_EXEC:   mem_wr_data = exec_flags;
			ST_REPORT: mem_wr_data = rpt_flags;
			default: begin
				// attention delivered, error no longer pending
				mem_wr_data = flags_q;
				mem_wr_data[OCCU_F_PENDING] = 1'b0;
			end
		endcase
	end

	// next state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_CLEAR:  if (sweep_done) state_d = ST_IDLE;
			ST_IDLE: begin
				if (cmd_take) state_d = ST_EXEC;
				else if (rpt_take) state_d = ST_REPORT;
			end
			ST_EXEC:   state_d = ST_STATUS;
			ST_STATUS: begin
				if (stat_accept) begin
					state_d = attn_after_q ? ST_ATTN : ST_IDLE;
				end
			end
			ST_ATTN:   if (stat_accept) state_d = ST_IDLE;
			ST_REPORT: state_d = rpt_attn ? ST_ATTN : ST_IDLE;
		endcase
	end

	// sequencer and reset sweep
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q   <= ST_CLEAR;
			clr_cnt_q <= '0;
		end else if (clk_en) begin
			state_q <= state_d;
			if (state_q == ST_CLEAR) begin
				clr_cnt_q <= clr_cnt_q + 6'h01;
			end
		end
	end

	// latch the request being served
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			addr_q       <= '0;
			code_q       <= 8'h00;
			kind_q       <= OCCU_KIND_DISPLAY_GEN;
			cfg_q        <= 1'b0;
			ustate_q     <= 2'h0;
			power_lost_q <= 1'b0;
		end else if (clk_en) begin
			if (cmd_take) begin
				// flags of this address indexed at selection
				addr_q   <= cmd_addr;
				code_q   <= cmd_code;
				kind_q   <= cmd_kind;
				cfg_q    <= dev_configured;
				ustate_q <= unit_state;
			end else if (rpt_take) begin
				addr_q       <= dev_rpt_addr;
				power_lost_q <= dev_power_lost;
			end
		end
	end

	// flags of the address in work and pending attention
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			flags_q      <= OCCU_FLAGS_RST;
			attn_after_q <= 1'b0;
		end else if (clk_en) begin
			unique case (state_q)
				ST_EXEC: begin
					flags_q      <= exec_flags;
					attn_after_q <= exec_attn;
				end
				ST_REPORT: flags_q <= rpt_flags;
				default:   flags_q <= flags_q;
			endcase
		end
	end

	// channel status byte
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stat_valid_q <= 1'b0;
			stat_byte_q  <= 8'h00;
		end else if (clk_en) begin
			if (state_d == ST_STATUS && state_q == ST_EXEC) begin
				stat_valid_q <= 1'b1;
				stat_byte_q  <= exec_stat;
			end else if (state_d == ST_ATTN && state_q != ST_ATTN) begin
				// attention stands alone in its own byte
				stat_valid_q <= 1'b1;
				stat_byte_q  <= OCCU_ST_ATTENTION;
			end else if (stat_accept) begin
				stat_valid_q <= 1'b0;
				stat_byte_q  <= 8'h00;
			end
		end
	end

	// one-cycle order and communication pulses
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ord_valid_q      <= 1'b0;
			ord_code_q       <= OCCU_ORD_RESUME;
			ord_addr_q       <= '0;
			comm_upd_valid_q <= 1'b0;
			comm_upd_addr_q  <= '0;
			comm_upd_on_q    <= 1'b0;
		end else if (clk_en) begin
			// only configured devices receive orders
			ord_valid_q <= (state_q == ST_EXEC) & cmd_ok & is_order;
			ord_addr_q  <= addr_q;
			if (cmd == OCCU_CMD_RESUME) begin
				ord_code_q <= OCCU_ORD_RESUME;
			end else if (cmd == OCCU_CMD_DISABLE_INTF) begin
				ord_code_q <= OCCU_ORD_DISABLE_INTF;
			end else begin
				ord_code_q <= OCCU_ORD_TEST;
			end
			comm_upd_valid_q <= (state_q == ST_EXEC) & comm_live;
			comm_upd_addr_q  <= addr_q;
			comm_upd_on_q    <= (cmd == OCCU_CMD_COMM_ON);
		end
	end

	// ready flags and report acknowledge
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmd_ready_q <= 1'b0;
			rpt_ready_q <= 1'b0;
			rpt_ack_q   <= 1'b0;
		end else if (clk_en) begin
			cmd_ready_q <= (state_d == ST_IDLE);
			rpt_ready_q <= (state_d == ST_IDLE);
			rpt_ack_q   <= rpt_take;
		end
	end

	// per-device flag words
	occu_flag_mem u_flags (
		.clk       (clk),
		.clk_en    (clk_en),
		.rd_addr   (mem_rd_addr),
		.rd_data_q (mem_rd),
		.wr_en     (mem_we),
		.wr_addr   (mem_wr_addr),
		.wr_data   (mem_wr_data)
	);

	// report bytes, test bit folded in once flags are known
	occu_report_fmt u_fmt (
		.clk         (clk),
		.sys_rst     (sys_rst),
		.clk_en      (clk_en),
		.load        (rpt_take),
		.kind        (dev_rpt_kind),
		.raw0        (dev_rpt_raw0),
		.raw1        (dev_rpt_raw1),
		.console_map (console_map),
		.set_test    ((state_q == ST_REPORT) & mem_rd[OCCU_F_TEST]),
		.byte0_q     (rpt_byte0_q),
		.byte1_q     (rpt_byte1_q),
		.byte2_q     (rpt_byte2_q),
		.byte3_q     (rpt_byte3_q),
		.err_q       (fmt_err)
	);

endmodule

// [hw/occu_pkg.sv]
package occu_pkg;

	// command unit commands, as decoded from the control byte
	typedef enum logic [2:0] {
		OCCU_CMD_NONE,
		OCCU_CMD_RESUME,
		OCCU_CMD_DISABLE_INTF,
		OCCU_CMD_TEST,
		OCCU_CMD_ATTN_ON,
		OCCU_CMD_ATTN_OFF,
		OCCU_CMD_COMM_ON,
		OCCU_CMD_COMM_OFF
	} occu_cmd_t;

	// kinds of outboard device behind an address
	typedef enum logic [1:0] {
		OCCU_KIND_DISPLAY_GEN,
		OCCU_KIND_KEYBOARD_MUX,
		OCCU_KIND_RADAR_CONSOLE,
		OCCU_KIND_DATA_ADAPTER
	} occu_kind_t;

	// orders forwarded to the addressed device
	typedef enum logic [1:0] {
		OCCU_ORD_RESUME,
		OCCU_ORD_DISABLE_INTF,
		OCCU_ORD_TEST
	} occu_ord_t;

	// control byte codes
	localparam logic [7:0] OCCU_CODE_RESUME       = 8'h57;
	localparam logic [7:0] OCCU_CODE_DISABLE_INTF = 8'h77;
	localparam logic [7:0] OCCU_CODE_TEST         = 8'h67;
	localparam logic [7:0] OCCU_CODE_ATTN_ON      = 8'h9f;
	localparam logic [7:0] OCCU_CODE_ATTN_OFF     = 8'h1f;
	localparam logic [7:0] OCCU_CODE_COMM_ON      = 8'haf;
	localparam logic [7:0] OCCU_CODE_COMM_OFF     = 8'h2f;

	// channel status byte, bit 0 is the most significant bit
	localparam logic [7:0] OCCU_ST_ATTENTION  = 8'h80;
	localparam logic [7:0] OCCU_ST_CHAN_END   = 8'h08;
	localparam logic [7:0] OCCU_ST_DEV_END    = 8'h04;
	localparam logic [7:0] OCCU_ST_UNIT_CHECK = 8'h02;
	localparam logic [7:0] OCCU_ST_UNIT_EXC   = 8'h01;

	// unit operating states
	localparam logic [1:0] OCCU_STATE_ZERO  = 2'h0;
	localparam logic [1:0] OCCU_STATE_THREE = 2'h3;

	// device address space and per-device flag word
	localparam int         OCCU_AW         = 6;
	localparam int         OCCU_FW         = 4;
	localparam logic [5:0] OCCU_ADDR_LAST  = 6'h3f;
	localparam int         OCCU_F_ATTN_EN  = 0;
	localparam int         OCCU_F_COMM     = 1;
	localparam int         OCCU_F_TEST     = 2;
	localparam int         OCCU_F_PENDING  = 3;
	localparam logic [3:0] OCCU_FLAGS_RST  = 4'h0;

	// report byte masks, bit 0 is the most significant bit
	localparam logic [7:0] OCCU_DG_ERR0_MASK  = 8'h3f;
	localparam logic [7:0] OCCU_DG_ERR1_MASK  = 8'he0;
	localparam logic [7:0] OCCU_DG_TEST_BIT   = 8'h10;
	localparam logic [7:0] OCCU_KM_ERR0_MASK  = 8'h3d;
	localparam logic [7:0] OCCU_KM_ERR1_MASK  = 8'hfe;
	localparam logic [7:0] OCCU_KM_TEST_BIT   = 8'h01;
	localparam logic [7:0] OCCU_BYTE_ZERO     = 8'h00;

	// bit n of a byte in channel numbering sits at vector index 7-n
	function automatic logic [2:0] occu_msb(input logic [2:0] n);
		return 3'h7 - n;
	endfunction

	// control byte to command
	function automatic occu_cmd_t occu_decode(input logic [7:0] code);
		unique case (code)
			OCCU_CODE_RESUME:       return OCCU_CMD_RESUME;
			OCCU_CODE_DISABLE_INTF: return OCCU_CMD_DISABLE_INTF;
			OCCU_CODE_TEST:         return OCCU_CMD_TEST;
			OCCU_CODE_ATTN_ON:      return OCCU_CMD_ATTN_ON;
			OCCU_CODE_ATTN_OFF:     return OCCU_CMD_ATTN_OFF;
			OCCU_CODE_COMM_ON:      return OCCU_CMD_COMM_ON;
			OCCU_CODE_COMM_OFF:     return OCCU_CMD_COMM_OFF;
			default:                return OCCU_CMD_NONE;
		endcase
	endfunction

endpackage

// [hw/occu_flag_mem.sv]
`timescale 1ns/100ps
// per-device flag store, one word per address, registered read
module occu_flag_mem
	import occu_pkg::*;
(
	// clock
	input  wire logic                clk,
	input  wire logic                clk_en,
	// read port
	input  wire logic [OCCU_AW-1:0]  rd_addr,
	output      logic [OCCU_FW-1:0]  rd_data_q,
	// write port
	input  wire logic                wr_en,
	input  wire logic [OCCU_AW-1:0]  wr_addr,
	input  wire logic [OCCU_FW-1:0]  wr_data
);

	logic [OCCU_FW-1:0] mem_q [2**OCCU_AW];  // flag words, cleared by sweep

	// read first, old word returned on a same-address write, read data always from a register
	always_ff @(posedge clk) begin
		if (clk_en) begin
			if (wr_en) begin
				mem_q[wr_addr] <= wr_data;
			end
			rd_data_q <= mem_q[rd_addr];
		end
	end

endmodule

// [hw/occu_report_fmt.sv]
`timescale 1ns/100ps
// builds device status report and console map bytes
module occu_report_fmt
	import occu_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	// raw report from device
	input  wire logic        load,
	input  wire occu_kind_t  kind,
	input  wire logic [7:0]  raw0,
	input  wire logic [7:0]  raw1,
	input  wire logic [31:0] console_map,
	input  wire logic        set_test,
	// formatted bytes
	output      logic [7:0]  byte0_q,
	output      logic [7:0]  byte1_q,
	output      logic [7:0]  byte2_q,
	output      logic [7:0]  byte3_q,
	output      logic        err_q
);

	logic       is_dg;     // display generator report
	logic       is_km;     // keyboard multiplexer report
	logic [7:0] test_bit;  // test bit for this kind
	logic [7:0] map_b [4]; // console map, console 1 at byte 0 bit 0
	occu_kind_t kind_q;    // kind held from the load

	assign is_dg = (kind_q == OCCU_KIND_DISPLAY_GEN);
	assign is_km = (kind_q == OCCU_KIND_KEYBOARD_MUX);
	assign test_bit = is_dg ? OCCU_DG_TEST_BIT :
		(is_km ? OCCU_KM_TEST_BIT : OCCU_BYTE_ZERO);

	// reorder console bits so channel bit k of byte n is console 8n+k+1
	always_comb begin
		for (int n = 0; n < 4; n++) begin
			map_b[n] = OCCU_BYTE_ZERO;
			for (int k = 0; k < 8; k++) begin
				map_b[n][occu_msb(3'(k))] = console_map[8*n+k];
			end
		end
	end

	// capture and mask the report on load
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			byte0_q <= OCCU_BYTE_ZERO;
			byte1_q <= OCCU_BYTE_ZERO;
			byte2_q <= OCCU_BYTE_ZERO;
			byte3_q <= OCCU_BYTE_ZERO;
			err_q   <= 1'b0;
			kind_q  <= OCCU_KIND_DISPLAY_GEN;
		end else if (clk_en) begin
			if (load) begin
				kind_q <= kind;
				unique case (kind)
					OCCU_KIND_DISPLAY_GEN: begin
						// two bytes, test and unused bits dropped
						byte0_q <= raw0;
						byte1_q <= raw1 & OCCU_DG_ERR1_MASK;
						byte2_q <= OCCU_BYTE_ZERO;
						byte3_q <= OCCU_BYTE_ZERO;
						// temperature and relay supply never raise error
						err_q <= |(raw0 & OCCU_DG_ERR0_MASK)
							| |(raw1 & OCCU_DG_ERR1_MASK);
					end
					OCCU_KIND_KEYBOARD_MUX: begin
						// four bytes, last two unused
						byte0_q <= raw0;
						byte1_q <= raw1 & OCCU_KM_ERR1_MASK;
						byte2_q <= OCCU_BYTE_ZERO;
						byte3_q <= OCCU_BYTE_ZERO;
						// bits 0, 1 and 6 of byte zero are polled only
						err_q <= |(raw0 & OCCU_KM_ERR0_MASK)
							| |(raw1 & OCCU_KM_ERR1_MASK);
					end
					OCCU_KIND_RADAR_CONSOLE: begin
						// console map goes out as four bytes
						byte0_q <= map_b[0];
						byte1_q <= map_b[1];
						byte2_q <= map_b[2];
						byte3_q <= map_b[3];
						err_q   <= 1'b0;
					end
					OCCU_KIND_DATA_ADAPTER: begin
						// no report for this kind
						byte0_q <= OCCU_BYTE_ZERO;
						byte1_q <= OCCU_BYTE_ZERO;
						byte2_q <= OCCU_BYTE_ZERO;
						byte3_q <= OCCU_BYTE_ZERO;
						err_q   <= 1'b0;
					end
				endcase
			end else if (set_test) begin
				// test order seen by this device
				byte1_q <= byte1_q | test_bit;
			end
		end
	end

endmodule

// [verif/occu_command_unit_checker.sv]
`timescale 1ns/100ps
// watches command answers, orders and report attention at the unit ports
module occu_command_unit_checker
	import occu_pkg::*;
(
	// clock and reset
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       clk_en,
	// command side
	input wire logic       cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic [5:0] cmd_addr,
	input wire occu_kind_t cmd_kind,
	input wire logic       dev_configured,
	input wire logic [1:0] unit_state,
	input wire logic       cmd_ready_q,
	// status, orders, communication updates
	input wire logic       stat_valid_q,
	input wire logic [7:0] stat_byte_q,
	input wire logic       ord_valid_q,
	input wire occu_ord_t  ord_code_q,
	input wire logic [5:0] ord_addr_q,
	input wire logic       comm_upd_valid_q,
	input wire logic       comm_upd_on_q,
	// device reports
	input wire logic       dev_rpt_valid,
	input wire occu_kind_t dev_rpt_kind,
	input wire logic [7:0] dev_rpt_raw0,
	input wire logic [7:0] dev_rpt_raw1,
	input wire logic       dev_power_lost,
	input wire logic       rpt_ready_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// command taken, kind valid, communication code, order code
	wire       tk = clk_en && cmd_valid && cmd_ready_q;
	wire       vk = cmd_kind != OCCU_KIND_DATA_ADAPTER;
	wire       cm = cmd_code inside {8'haf, 8'h2f};
	wire       od = cmd_code inside {8'h57, 8'h77, 8'h67};
	occu_ord_t eo;
	// report taken
	wire       rk = clk_en && dev_rpt_valid && rpt_ready_q && !cmd_valid;
	// order expected for the code
	assign eo = cmd_code == 8'h57 ? OCCU_ORD_RESUME :
		(cmd_code == 8'h77 ? OCCU_ORD_DISABLE_INTF : OCCU_ORD_TEST);

	a_cmd_status: assert property (tk |-> ##2 stat_valid_q)
		else $error("no status two edges after a command");
	a_order_sent: assert property (tk && vk && dev_configured && od |-> ##2
		ord_valid_q && ord_code_q == $past(eo, 2) &&
		ord_addr_q == $past(cmd_addr, 2) && stat_byte_q == 8'h0c)
		else $error("order or ending status wrong");
	a_not_config: assert property (tk && vk && !dev_configured && !cm &&
		(od || cmd_code inside {8'h9f, 8'h1f}) |-> ##2
		stat_byte_q == 8'h01 && !ord_valid_q)
		else $error("unconfigured device not refused");
	a_comm_refuse: assert property (tk && vk && cm &&
		unit_state inside {2'h1, 2'h2} |-> ##2
		stat_byte_q == 8'h01 && !comm_upd_valid_q)
		else $error("communication in state one or two not refused");
	a_comm_update: assert property (tk && vk && cm && dev_configured &&
		unit_state == 2'h3 |-> ##2 comm_upd_valid_q &&
		comm_upd_on_q == ($past(cmd_code, 2) == 8'haf))
		else $error("communication bit update wrong");
	a_comm_maint: assert property (tk && cm && unit_state == 2'h0 |->
		##2 !comm_upd_valid_q)
		else $error("communication changed in state zero");
	a_attn_local: assert property (tk && cmd_code inside {8'h9f, 8'h1f}
		|-> ##2 stat_valid_q && !ord_valid_q)
		else $error("attention code forwarded");
	a_dg_polled: assert property (rk && !dev_power_lost &&
		dev_rpt_kind == OCCU_KIND_DISPLAY_GEN && dev_rpt_raw1[7:5] == 3'h0
		&& (dev_rpt_raw0 & 8'h3f) == 8'h00 |-> ##2 !stat_valid_q)
		else $error("polled display condition raised attention");

	c_attention: cover property (stat_valid_q && stat_byte_q == 8'h80);
	c_comm_upd: cover property (comm_upd_valid_q);
	c_order: cover property (ord_valid_q);
endmodule

bind occu_command_unit occu_command_unit_checker u_chk (.*);

// [verif/occu_chan_model.sv]
`timescale 1ns/100ps
// channel end: takes each status byte after a chosen delay
module occu_chan_model
	import occu_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// status byte offered by the unit
	input  wire logic       stat_valid_q,
	input  wire logic [7:0] stat_byte_q,
	output      logic       stat_accept,
	// wait before taking, zero is prompt
	input  wire logic [1:0] dly,
	// last byte taken, bytes taken so far
	output      logic [7:0] last_q,
	output      logic [7:0] nacc_q
);
	logic [1:0] cnt_q; // cycles the byte has waited

	// waits, then pulses accept once and records the byte
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stat_accept <= 1'b0;
			cnt_q       <= 2'h0;
			last_q      <= 8'h00;
			nacc_q      <= 8'h00;
		end else if (stat_accept) begin
			stat_accept <= 1'b0;
			cnt_q       <= 2'h0;
		end else if (stat_valid_q) begin
			cnt_q <= cnt_q + 2'h1;
			if (cnt_q == dly) begin
				stat_accept <= 1'b1;
				last_q      <= stat_byte_q;
				nacc_q      <= nacc_q + 8'h01;
			end
		end
	end
endmodule

// [verif/outboard_control_command_unit_tb_top.sv]
`timescale 1ns/100ps
// drives commands and device reports, checks status, orders and bytes
module outboard_control_command_unit_tb_top
	import occu_pkg::*;
;
	// inputs of the unit
	logic       clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
	logic       cmd_valid = 1'b0, dev_configured = 1'b0;
	logic [7:0] cmd_code = 8'h00, dev_rpt_raw0 = 8'h00, dev_rpt_raw1 = 8'h00;
	logic [5:0] cmd_addr = 6'h00, dev_rpt_addr = 6'h00;
	occu_kind_t cmd_kind = OCCU_KIND_DISPLAY_GEN;
	occu_kind_t dev_rpt_kind = OCCU_KIND_DISPLAY_GEN;
	logic [1:0] unit_state = 2'h3, dly = 2'h0;
	logic       dev_rpt_valid = 1'b0, dev_power_lost = 1'b0;
	logic [31:0] console_map = 32'h0;
	// outputs of the unit and the channel model
	logic       cmd_ready_q, stat_valid_q, stat_accept, ord_valid_q;
	logic       comm_upd_valid_q, comm_upd_on_q, rpt_ready_q, rpt_ack_q;
	logic [7:0] stat_byte_q, last_q, nacc_q;
	logic [7:0] rpt_byte0_q, rpt_byte1_q, rpt_byte2_q, rpt_byte3_q;
	logic [5:0] ord_addr_q, comm_upd_addr_q;
	occu_ord_t  ord_code_q;
	// bookkeeping and command table
	int         fail_count = 0, n_tests = 0, i;
	logic [7:0] codes [8] = '{8'h57, 8'h77, 8'h67, 8'h9f, 8'h1f, 8'haf,
		8'h2f, 8'h00};

	occu_command_unit DUT (.*);
	occu_chan_model u_chan (.*);

	// compares one value, counts and reports
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// verdict and end of run
	task automatic report_and_stop();
		if (fail_count == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// expected ending status: unit check, exception or normal end
	function automatic logic [7:0] exp_st(input logic [7:0] c,
		input occu_kind_t k, input logic [1:0] s, input logic f);
		if (!(c inside {8'h57, 8'h77, 8'h67, 8'h9f, 8'h1f, 8'haf, 8'h2f})
			|| k == OCCU_KIND_DATA_ADAPTER) return 8'h02;
		if (c inside {8'haf, 8'h2f} && s inside {2'h1, 2'h2}) return 8'h01;
		if (!f) return 8'h01;
		return 8'h0c;
	endfunction

	// waits, bounded, until both sides of the unit are idle
	task automatic idle();
		for (int j = 0; j < 200 && !(cmd_ready_q && rpt_ready_q); j++)
			@(posedge clk);
	endtask

	// one command, its answer, order and any attention byte
	task automatic cmd(input logic [7:0] c, input logic [5:0] a,
		input occu_kind_t k, input logic [1:0] s, input logic f,
		input logic pa);
		logic [7:0] e;
		logic [7:0] n0;
		logic       od;
		logic       at;
		e = exp_st(c, k, s, f);
		od = e == 8'h0c && c inside {8'h57, 8'h77, 8'h67};
		at = (od && c == 8'h67 && s == 2'h0) || pa;
		n0 = nacc_q;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_addr <= a;
		cmd_kind <= k;
		unit_state <= s;
		dev_configured <= f;
		do @(posedge clk); while (!cmd_ready_q);
		cmd_valid <= 1'b0;
		@(posedge clk);
		#1;
		chk(stat_byte_q, e);
		chk(ord_valid_q, od);
		if (od) chk(ord_code_q, c == 8'h57 ? OCCU_ORD_RESUME :
			(c == 8'h77 ? OCCU_ORD_DISABLE_INTF : OCCU_ORD_TEST));
		if (od) chk(ord_addr_q, a);
		chk(comm_upd_valid_q, e == 8'h0c && c inside {8'haf, 8'h2f}
			&& s == 2'h3);
		if (comm_upd_valid_q === 1'b1) chk({comm_upd_on_q, comm_upd_addr_q},
			{c == 8'haf, a});
		idle();
		chk(last_q, at ? 8'h80 : e);
		chk(8'(nacc_q - n0), at ? 2 : 1);
	endtask

	// one device report, its bytes and whether attention follows
	task automatic rpt(input occu_kind_t k, input logic [5:0] a,
		input logic [7:0] r0, input logic [31:0] m, input logic ea,
		input logic [31:0] eb);
		logic [7:0] n0;
		n0 = nacc_q;
		@(posedge clk);
		dev_rpt_valid <= 1'b1;
		dev_rpt_kind <= k;
		dev_rpt_addr <= a;
		dev_rpt_raw0 <= r0;
		console_map <= m;
		do @(posedge clk); while (!rpt_ready_q);
		dev_rpt_valid <= 1'b0;
		#1;
		chk(rpt_ack_q, 1'b1);
		@(posedge clk);
		#1;
		chk({rpt_byte0_q, rpt_byte1_q}, eb[31:16]);
		chk({rpt_byte2_q, rpt_byte3_q}, eb[15:0]);
		chk(stat_valid_q, ea);
		idle();
		chk(8'(nacc_q - n0), ea);
	endtask

	// clock, 40 ns period
	initial begin
		forever #20 clk = ~clk;
	end

	// watchdog against a hang
	initial begin
		repeat (6000) @(posedge clk);
		fail_count++;
		report_and_stop();
	end

	// main sequence
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		for (i = 0; i < 64; i++) begin
			dly <= i[1:0];
			cmd(codes[i / 8], 6'h05, occu_kind_t'(i % 4), 2'h3, i[2], 1'b0);
		end
		for (i = 0; i < 8; i++)
			cmd(i[0] ? 8'h2f : 8'haf, 6'h09, OCCU_KIND_KEYBOARD_MUX, i[2:1], 1'b1, 1'b0);
		cmd(8'h67, 6'h07, OCCU_KIND_RADAR_CONSOLE, 2'h0, 1'b1, 1'b0);
		rpt(OCCU_KIND_DISPLAY_GEN, 6'h0c, 8'h20, 32'h0, 1'b0, 32'h20000000);
		cmd(8'h9f, 6'h0c, OCCU_KIND_DISPLAY_GEN, 2'h3, 1'b1, 1'b1);
		rpt(OCCU_KIND_DISPLAY_GEN, 6'h0c, 8'hc0, 32'h0, 1'b0, 32'hc0000000);
		cmd(8'h9f, 6'h06, OCCU_KIND_KEYBOARD_MUX, 2'h3, 1'b1, 1'b0);
		rpt(OCCU_KIND_KEYBOARD_MUX, 6'h06, 8'hc2, 32'h0, 1'b0, 32'hc2000000);
		rpt(OCCU_KIND_KEYBOARD_MUX, 6'h06, 8'h01, 32'h0, 1'b1, 32'h01000000);
		cmd(8'h67, 6'h0c, OCCU_KIND_DISPLAY_GEN, 2'h3, 1'b1, 1'b0);
		rpt(OCCU_KIND_DISPLAY_GEN, 6'h0c, 8'h00, 32'h0, 1'b0, 32'h00100000);
		cmd(8'h67, 6'h06, OCCU_KIND_KEYBOARD_MUX, 2'h3, 1'b1, 1'b0);
		rpt(OCCU_KIND_KEYBOARD_MUX, 6'h06, 8'h00, 32'h0, 1'b0, 32'h00010000);
		dev_power_lost <= 1'b1;
		rpt(OCCU_KIND_KEYBOARD_MUX, 6'h06, 8'h00, 32'h0, 1'b1, 32'h0);
		dev_power_lost <= 1'b0;
		rpt(OCCU_KIND_RADAR_CONSOLE, 6'h14, 8'h00, 32'h201, 1'b0, 32'h80400000);
		clk_en <= 1'b0;
		cmd_valid <= 1'b1;
		repeat (3) @(posedge clk);
		cmd_valid <= 1'b0;
		clk_en <= 1'b1;
		chk(stat_valid_q, 1'b0);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rpt(OCCU_KIND_KEYBOARD_MUX, 6'h06, 8'h01, 32'h0, 1'b0, 32'h01000000);
		report_and_stop();
	end
endmodule
